//--- host_buffer_dma_setup_tb.sv
// Testbench driving the host end over APB with the device end on the link.
`timescale 1ns/1ps
`include "xfer_consts.svh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fails++; $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module host_buffer_dma_setup_tb;
  import xfer_pkg::*;
  logic        mclk, rst, psel, penable, pwrite, pready, pslverr, perr;
  logic [7:0]  paddr, s, acks0;
  logic [31:0] pwdata, prdata, q;
  logic        done_flag, upd, dir_sel;
  logic [2:0]  sel;
  logic [1:0]  burst;
  logic [15:0] v;
  int          fails, compares, cycles, done_cnt, upd_cnt;

  proc_link link();
  proc_dma_host u_proc_dma_host (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link.hst));
  transfer_setup_dev u_transfer_setup_dev (.mclk(mclk), .rst(rst), .link(link.dev),
    .transfer_done_flag(done_flag), .buffer_state_update(upd), .buffer_state_sel(sel),
    .burst_size_select(burst), .direction_select(dir_sel));
  xfer_link_sva u_xfer_link_sva (.mclk(mclk), .rst(rst), .cmd_stb(link.cmd_stb), .cmd_code(link.cmd_code),
    .cmd_wdata(link.cmd_wdata), .cmd_rvalid(link.cmd_rvalid), .cmd_rdata(link.cmd_rdata),
    .transfer_request(link.transfer_request), .dma_ack(link.dma_ack), .dma_rvalid(link.dma_rvalid),
    .end_of_transfer(link.end_of_transfer));

  // ----------------------------------------------------------------
  // Clock, pulse counters and run limit
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Update is counted before done so a waiter never sees done ahead of it.
  always @(posedge mclk) begin
    cycles++;
    if (upd === 1'b1) upd_cnt++;
    if (done_flag === 1'b1) done_cnt++;
    if (cycles == 20000) begin
      fails++;
      close_out();
    end
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic cmd(input logic [7:0] c, input logic [15:0] d);
    apb(1'b1, `HOFS_CMD, {d, 8'h00, c});
  endtask : cmd

  task automatic rdc(input logic [7:0] c, output logic [15:0] r);
    cmd(c, 16'h0000);
    do apb(1'b0, `HOFS_STATUS, 32'h0); while (q[0] !== 1'b0);
    apb(1'b0, `HOFS_RDATA, 32'h0);
    r = q[15:0];
  endtask : rdc

  task automatic wait_done(input int n);
    while (done_cnt < n) @(posedge mclk);
  endtask : wait_done

  task automatic close_out;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rdc(`CMD_RD_SETUP, v); `CHK(v, 16'h0000)
    rdc(`CMD_RD_COUNT, v); `CHK(v, 16'h0000)
    apb(1'b0, 8'h14, 32'h0); `CHK(perr, 1'b1)
    $display("test reset done");
    // Go stays low here, so every field combination is safe to park.
    for (int i = 0; i < 8; i++) begin
      cmd(`CMD_WR_COUNT, 16'h1230 + 16'(i));
      rdc(`CMD_RD_COUNT, v); `CHK(v, 16'h1230 + 16'(i))
      s = {1'b1, 2'(i), 1'b0, 3'(i), i[0]};
      cmd(`CMD_WR_SETUP, {8'h00, s});
      rdc(`CMD_RD_SETUP, v); `CHK(v, {8'h00, s})
      `CHK(burst, s[6:5])
      `CHK(dir_sel, s[0])
    end
    $display("test fields done");
    apb(1'b0, `HOFS_STATUS, 32'h0); acks0 = q[15:8];
    cmd(`CMD_WR_COUNT, 16'h0004);
    apb(1'b1, `HOFS_CTRL, 32'h1);
    cmd(`CMD_WR_SETUP, 16'h0090);
    wait_done(1);
    `CHK(upd_cnt, 1)
    `CHK(sel, 3'b000)
    apb(1'b0, `HOFS_STATUS, 32'h0);
    `CHK(q[15:8] - acks0, 8'h02)
    `CHK(q[1], 1'b0)
    rdc(`CMD_RD_SETUP, v); `CHK(v, 16'h0080)
    $display("test dma read done");
    apb(1'b1, `HOFS_DMA_WDATA, 32'h0000_5a5a);
    apb(1'b0, `HOFS_STATUS, 32'h0); acks0 = q[15:8];
    cmd(`CMD_WR_COUNT, 16'h0009);
    cmd(`CMD_WR_SETUP, 16'h00b7);
    wait_done(2);
    `CHK(sel, 3'b011)
    apb(1'b0, `HOFS_STATUS, 32'h0);
    `CHK(q[15:8] - acks0, 8'h05)
    cmd(`CMD_WR_COUNT, 16'h0005);
    rdc(`CMD_RD_DATA, v); `CHK(v, 16'h5a5a)
    $display("test dma write done");
    cmd(`CMD_WR_COUNT, 16'h0002);
    cmd(`CMD_WR_SETUP, 16'h0096);
    wait_done(3);
    apb(1'b0, `HOFS_STATUS, 32'h0); `CHK(q[31:16], 16'h5a5a)
    $display("test dma readback done");
    cmd(`CMD_WR_COUNT, 16'h0004);
    cmd(`CMD_WR_SETUP, 16'h0018);
    repeat (10) @(posedge mclk);
    apb(1'b0, `HOFS_STATUS, 32'h0); `CHK(q[1], 1'b0)
    cmd(`CMD_WR_SETUP, 16'h0000);
    cmd(`CMD_WR_COUNT, 16'h0000);
    cmd(`CMD_WR_SETUP, 16'h0090);
    repeat (10) @(posedge mclk);
    apb(1'b0, `HOFS_STATUS, 32'h0); `CHK(q[1], 1'b0)
    $display("test no start done");
    apb(1'b1, `HOFS_CTRL, 32'h0);
    cmd(`CMD_WR_SETUP, 16'h0000);
    cmd(`CMD_WR_COUNT, 16'h0100);
    cmd(`CMD_WR_SETUP, 16'h0090);
    apb(1'b0, `HOFS_STATUS, 32'h0); `CHK(q[1], 1'b1)
    apb(1'b1, `HOFS_CTRL, 32'h2);
    wait_done(4);
    `CHK(upd_cnt, 4)
    rdc(`CMD_RD_SETUP, v); `CHK(v, 16'h0080)
    $display("test abort done");
    cmd(`CMD_WR_COUNT, 16'h0004);
    cmd(`CMD_WR_SETUP, 16'h0083);
    cmd(`CMD_WR_DATA, 16'habcd);
    cmd(`CMD_WR_DATA, 16'h1357);
    wait_done(5);
    `CHK(sel, 3'b001)
    cmd(`CMD_WR_COUNT, 16'h0004);
    rdc(`CMD_RD_DATA, v); `CHK(v, 16'habcd)
    rdc(`CMD_RD_DATA, v); `CHK(v, 16'h1357)
    rdc(`CMD_RD_DATA, v); `CHK(v, 16'h0000)
    cmd(`CMD_WR_COUNT, 16'h0004);
    rdc(`CMD_RD_DATA, v); `CHK(v, 16'habcd)
    $display("test pio done");
    close_out();
  end
endmodule : host_buffer_dma_setup_tb

//--- proc_dma_host.sv
// Microprocessor side: APB registers that issue link commands and answer DMA requests.
`timescale 1ns/1ps
`include "xfer_consts.svh"

module proc_dma_host
  import xfer_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  proc_link.hst            link
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  host_state_e state_r;
  logic        pready_r;
  logic        pslverr_r;
  logic [31:0] prdata_r;
  logic        cmd_stb_r;
  logic [7:0]  cmd_code_r;
  logic [15:0] cmd_wdata_r;
  logic [15:0] rdata_r;
  logic        auto_ack_r;
  logic        eot_r;
  logic        ack_r;
  logic [15:0] dma_wdata_r;
  logic [15:0] dma_last_r;
  logic [7:0]  ack_cnt_r;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire        busy     = state_r == H_WAIT_RD;
  wire        access   = psel && penable && !pready_r;
  wire        hit_cmd  = paddr == `HOFS_CMD;
  wire        hold     = hit_cmd && pwrite && busy;
  wire        take     = access && !hold;
  wire        issue    = take && hit_cmd && pwrite;  // R10 R11
  wire        mapped   = hit_cmd || paddr == `HOFS_RDATA || paddr == `HOFS_CTRL ||
                         paddr == `HOFS_DMA_WDATA || paddr == `HOFS_STATUS;
  wire        wr_ctrl  = take && pwrite && paddr == `HOFS_CTRL;
  wire        wr_dwr   = take && pwrite && paddr == `HOFS_DMA_WDATA;
  wire [31:0] status   = {dma_last_r, ack_cnt_r, 6'h00, link.transfer_request, busy};
  wire [31:0] rd_mux   = (paddr == `HOFS_RDATA)     ? {16'h0000, rdata_r} :
                         (paddr == `HOFS_CTRL)      ? {31'h0, auto_ack_r} :
                         (paddr == `HOFS_DMA_WDATA) ? {16'h0000, dma_wdata_r} :
                         (paddr == `HOFS_STATUS)    ? status :
                         32'h0000_0000;

  // ----------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= take;
      pslverr_r <= take && !mapped;
      prdata_r  <= (take && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Command issue
  // ----------------------------------------------------------------
  // A read command parks the sequencer until the answer; a further command write stalls the bus.
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r     <= H_IDLE;
      cmd_stb_r   <= 1'b0;
      cmd_code_r  <= 8'h00;
      cmd_wdata_r <= 16'h0000;
      rdata_r     <= 16'h0000;
    end else begin
      cmd_stb_r <= issue;
      if (issue) begin
        cmd_code_r  <= pwdata[7:0];
        cmd_wdata_r <= pwdata[31:16];
      end
      case (state_r)
        H_IDLE: begin
          if (issue && !pwdata[`CMD_WRITE_BIT]) begin
            state_r <= H_WAIT_RD;
          end
        end
        H_WAIT_RD: begin
          if (link.cmd_rvalid) begin
            rdata_r <= link.cmd_rdata;
            state_r <= H_IDLE;
          end
        end
        default: state_r <= H_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // DMA answer
  // ----------------------------------------------------------------
  // Acknowledges are spaced one idle cycle apart so none lands after the request drop that its predecessor caused.
  always_ff @(posedge mclk) begin
    if (rst) begin
      auto_ack_r  <= 1'b0;
      eot_r       <= 1'b0;
      ack_r       <= 1'b0;
      dma_wdata_r <= 16'h0000;
      dma_last_r  <= 16'h0000;
      ack_cnt_r   <= 8'h00;
    end else begin
      eot_r <= wr_ctrl && pwdata[1];
      ack_r <= auto_ack_r && link.transfer_request && !ack_r;  // R02
      if (wr_ctrl) begin
        auto_ack_r <= pwdata[0];
      end
      if (wr_dwr) begin
        dma_wdata_r <= pwdata[15:0];
      end
      if (link.dma_rvalid) begin
        dma_last_r <= link.dma_rdata;
      end
      if (ack_r) begin
        ack_cnt_r <= ack_cnt_r + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata               = prdata_r;
  assign pready               = pready_r;
  assign pslverr              = pslverr_r;
  assign link.cmd_stb         = cmd_stb_r;
  assign link.cmd_code        = cmd_code_r;
  assign link.cmd_wdata       = cmd_wdata_r;
  assign link.dma_ack         = ack_r;
  assign link.dma_wdata       = dma_wdata_r;
  assign link.end_of_transfer = eot_r;

endmodule : proc_dma_host

//--- proc_link.sv
// Processor port between the microprocessor side and the buffer transfer controller.
`timescale 1ns/1ps
interface proc_link;
  logic        cmd_stb;
  logic [7:0]  cmd_code;
  logic [15:0] cmd_wdata;
  logic        cmd_rvalid;
  logic [15:0] cmd_rdata;
  logic        transfer_request;
  logic        dma_ack;
  logic [15:0] dma_wdata;
  logic        dma_rvalid;
  logic [15:0] dma_rdata;
  logic        end_of_transfer;

  modport dev (
    input  cmd_stb, cmd_code, cmd_wdata, dma_ack, dma_wdata, end_of_transfer,
    output cmd_rvalid, cmd_rdata, transfer_request, dma_rvalid, dma_rdata
  );
  modport hst (
    output cmd_stb, cmd_code, cmd_wdata, dma_ack, dma_wdata, end_of_transfer,
    input  cmd_rvalid, cmd_rdata, transfer_request, dma_rvalid, dma_rdata
  );
endinterface : proc_link

//--- transfer_setup_dev.sv
// Buffer transfer controller: setup and byte count registers, request generation and buffer memory.
`timescale 1ns/1ps
`include "xfer_consts.svh"

// Function
// [R01] Count gate set: byte counter governs transfer
// [R02] Request needs nonzero count and go bit
// [R03] Direction bit: 0 reads, 1 writes buffer
// [R04] Counter counts bytes for PIO and DMA
// [R05] Three-bit select picks list or direct addressing
// [R06] Software sets count gate for count effect
// [R07] Count reached raises internal end-of-transfer event
// [R08] End of transfer updates buffer state
// [R09] Byte count: 16-bit read/write, resets zero
// [R10] Setup register: read 21h, write A1h
// [R11] Byte count register: read 22h, write A2h
// [R12] Burst size: 1, 4, 8 words; 11 reserved
// [R13] Hardware clears go on completion; no request then
module transfer_setup_dev
  import xfer_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  proc_link.dev            link,
  output logic             transfer_done_flag,
  output logic             buffer_state_update,
  output logic [2:0]       buffer_state_sel,
  output logic [1:0]       burst_size_select,
  output logic             direction_select
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] burst_words(input logic [1:0] code);
    case (code)
      BURST_FOUR:  burst_words = 4'd4;
      BURST_EIGHT: burst_words = 4'd8;
      default:     burst_words = 4'd1;
    endcase
  endfunction : burst_words

  function automatic logic [`BUF_ADDR_W-1:0] buf_base(input logic [2:0] sel);
    if (sel[2]) begin
      buf_base = `BASE_DIRECT;
    end else begin
      case (sel)
        SEL_ISO_B:    buf_base = `BASE_ISO_B;
        SEL_PERIODIC: buf_base = `BASE_PERIODIC;
        SEL_ASYNC:    buf_base = `BASE_ASYNC;
        default:      buf_base = `BASE_ISO_A;
      endcase
    end
  endfunction : buf_base

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]             setup_r;
  logic [15:0]            count_r;
  logic [15:0]            moved_r;
  logic [`BUF_ADDR_W-1:0] ptr_r;
  logic [3:0]             burst_cnt_r;
  logic                   req_r;
  logic                   cmd_rvalid_r;
  logic [15:0]            cmd_rdata_r;
  logic                   dma_rvalid_r;
  logic [15:0]            dma_rdata_r;
  logic                   done_r;
  logic                   upd_r;
  logic [2:0]             upd_sel_r;
  logic [15:0]            mem [0:`BUF_WORDS-1];

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire                   count_gate        = setup_r[`SETUP_GATE_BIT];
  wire                   transfer_go       = setup_r[`SETUP_GO_BIT];
  wire [2:0]             sel               = setup_r[`SETUP_SEL_LSB +: 3];
  wire                   dir_wr            = setup_r[`SETUP_DIR_BIT];
  wire [1:0]             burst_sel         = setup_r[`SETUP_BURST_LSB +: 2];
  wire                   wr_setup          = link.cmd_stb && link.cmd_code == `CMD_WR_SETUP;  // R10
  wire                   wr_count          = link.cmd_stb && link.cmd_code == `CMD_WR_COUNT;  // R11
  wire                   is_read           = link.cmd_stb && !link.cmd_code[`CMD_WRITE_BIT];
  wire                   pio_cmd           = link.cmd_stb &&
                                             (link.cmd_code == `CMD_RD_DATA || link.cmd_code == `CMD_WR_DATA);
  wire [15:0]            remain            = count_r - moved_r;
  wire                   armed             = count_gate && count_r != 16'h0000 && moved_r < count_r;  // R01 R06
  wire                   pio_move          = pio_cmd && armed;  // R04
  wire                   dma_move          = link.dma_ack && req_r;
  wire                   move              = pio_move || dma_move;
  wire [15:0]            step              = (remain >= 16'h0002) ? 16'h0002 : remain;
  wire [15:0]            moved_nxt         = moved_r + step;  // R04
  wire                   reached           = move && moved_nxt >= count_r;  // R07
  wire                   eot_pin           = link.end_of_transfer && transfer_go;
  wire                   done              = reached || eot_pin;
  wire [3:0]             burst_cnt_nxt     = burst_cnt_r + 4'd1;
  wire                   burst_end         = dma_move && burst_cnt_nxt == burst_words(burst_sel);  // R12
  wire                   go_rise           = wr_setup && link.cmd_wdata[`SETUP_GO_BIT] && !transfer_go;
  wire [`BUF_ADDR_W-1:0] addr              = buf_base(sel) + ptr_r;  // R05
  wire [15:0]            wr_word           = pio_move ? link.cmd_wdata : link.dma_wdata;
  wire                   store             = dir_wr && (dma_move ||
                                             (pio_move && link.cmd_code[`CMD_WRITE_BIT]));  // R03
  wire                   req_nxt           = transfer_go && armed && !done && !burst_end &&
                                             !wr_setup && !wr_count;  // R02 R13
  wire [15:0]            rd_mux            = (link.cmd_code == `CMD_RD_SETUP) ? {8'h00, setup_r} :
                                             (link.cmd_code == `CMD_RD_COUNT) ? count_r :
                                             (link.cmd_code == `CMD_RD_DATA && pio_move) ? mem[addr] :
                                             16'h0000;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // A setup write in the same cycle as completion wins over the hardware clear of go,
  // so software that rearms at the last byte is not silently dropped.
  always_ff @(posedge mclk) begin
    if (rst) begin
      setup_r <= `SETUP_RESET;
    end else if (wr_setup) begin
      setup_r <= link.cmd_wdata[7:0];  // R10
    end else if (done) begin
      setup_r[`SETUP_GO_BIT] <= 1'b0;  // R13
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      count_r <= `COUNT_RESET;  // R09
    end else if (wr_count) begin
      count_r <= link.cmd_wdata;  // R09 R11
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || wr_count || go_rise) begin
      moved_r <= 16'h0000;
      ptr_r   <= '0;
    end else if (move) begin
      moved_r <= moved_nxt;  // R04
      ptr_r   <= ptr_r + `BUF_ADDR_W'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || !transfer_go || burst_end) begin
      burst_cnt_r <= 4'd0;
    end else if (dma_move) begin
      burst_cnt_r <= burst_cnt_nxt;  // R12
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      req_r <= 1'b0;
    end else begin
      req_r <= req_nxt;  // R02
    end
  end

  // Direction picks whether a move stores into or fetches from the buffer memory.
  // A PIO read never stores, whatever the direction, so reading back cannot clobber the buffer.
  always_ff @(posedge mclk) begin
    if (store) begin
      mem[addr] <= wr_word;  // R03
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      dma_rvalid_r <= 1'b0;
      dma_rdata_r  <= 16'h0000;
    end else begin
      dma_rvalid_r <= dma_move && !dir_wr;  // R03
      if (dma_move && !dir_wr) begin
        dma_rdata_r <= mem[addr];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cmd_rvalid_r <= 1'b0;
      cmd_rdata_r  <= 16'h0000;
    end else begin
      cmd_rvalid_r <= is_read;
      if (is_read) begin
        cmd_rdata_r <= rd_mux;  // R10 R11
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      done_r    <= 1'b0;
      upd_r     <= 1'b0;
      upd_sel_r <= 3'b000;
    end else begin
      done_r <= done;  // R07
      upd_r  <= done;  // R08
      if (done) begin
        upd_sel_r <= sel;  // R08
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link.transfer_request = req_r;
  assign link.cmd_rvalid       = cmd_rvalid_r;
  assign link.cmd_rdata        = cmd_rdata_r;
  assign link.dma_rvalid       = dma_rvalid_r;
  assign link.dma_rdata        = dma_rdata_r;
  assign transfer_done_flag    = done_r;
  assign buffer_state_update   = upd_r;
  assign buffer_state_sel      = upd_sel_r;
  assign burst_size_select     = burst_sel;
  assign direction_select      = dir_wr;

endmodule : transfer_setup_dev

//--- xfer_consts.svh
// Command codes, register layouts, reset values and host register offsets for the transfer setup link.
`ifndef XFER_CONSTS_SVH
`define XFER_CONSTS_SVH

// ----------------------------------------------------------------
// Command codes on the processor port
// ----------------------------------------------------------------
`define CMD_RD_SETUP    8'h21
`define CMD_WR_SETUP    8'ha1
`define CMD_RD_COUNT    8'h22
`define CMD_WR_COUNT    8'ha2
`define CMD_RD_DATA     8'h40
`define CMD_WR_DATA     8'hc0
`define CMD_WRITE_BIT   7

// ----------------------------------------------------------------
// Transfer setup register fields and reset values
// ----------------------------------------------------------------
`define SETUP_GATE_BIT  7
`define SETUP_BURST_LSB 5
`define SETUP_GO_BIT    4
`define SETUP_SEL_LSB   1
`define SETUP_DIR_BIT   0
`define SETUP_RESET     8'h00
`define COUNT_RESET     16'h0000

// ----------------------------------------------------------------
// Buffer memory layout, in 16-bit words
// ----------------------------------------------------------------
`define BUF_ADDR_W      6
`define BUF_WORDS       64
`define BASE_ISO_A      6'h00
`define BASE_ISO_B      6'h10
`define BASE_PERIODIC   6'h20
`define BASE_ASYNC      6'h30
`define BASE_DIRECT     6'h00

// ----------------------------------------------------------------
// Host controller APB register offsets
// ----------------------------------------------------------------
`define HOFS_CMD        8'h00
`define HOFS_RDATA      8'h04
`define HOFS_CTRL       8'h08
`define HOFS_DMA_WDATA  8'h0c
`define HOFS_STATUS     8'h10

`endif

//--- xfer_link_sva.sv
// Concurrent checks on the processor link between the two ends.
`timescale 1ns/1ps
`include "xfer_consts.svh"
module xfer_link_sva
  import xfer_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        cmd_stb,
  input wire logic [7:0]  cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic        cmd_rvalid,
  input wire logic [15:0] cmd_rdata,
  input wire logic        transfer_request,
  input wire logic        dma_ack,
  input wire logic        dma_rvalid,
  input wire logic        end_of_transfer
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // Shadow copies of what software last wrote
  // ----------------------------------------------------------------
  logic [15:0] cnt_r;
  logic [7:0]  setup_r;
  wire         wr_cnt   = cmd_stb && cmd_code == `CMD_WR_COUNT;
  wire         wr_setup = cmd_stb && cmd_code == `CMD_WR_SETUP;

  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_r   <= `COUNT_RESET;
      setup_r <= `SETUP_RESET;
    end else if (wr_cnt) begin
      cnt_r <= cmd_wdata;
    end else if (wr_setup) begin
      setup_r <= cmd_wdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  read_answer_a: assert property (cmd_stb && !cmd_code[`CMD_WRITE_BIT] |=> cmd_rvalid)
    else $error("read command got no answer");
  answer_cause_a: assert property (cmd_rvalid |-> $past(cmd_stb && !cmd_code[`CMD_WRITE_BIT]))
    else $error("answer without read command");
  count_readback_a: assert property (cmd_stb && cmd_code == `CMD_RD_COUNT |=> cmd_rdata == cnt_r)
    else $error("byte count read differs from last write");
  // The go bit is left out: hardware may clear it at completion.
  setup_readback_a: assert property (cmd_stb && cmd_code == `CMD_RD_SETUP
      |=> {cmd_rdata[15:5], cmd_rdata[3:0]} == {8'h00, setup_r[7:5], setup_r[3:0]})
    else $error("setup read differs from last write");
  dma_read_a: assert property (dma_ack && transfer_request && !setup_r[0] |=> dma_rvalid)
    else $error("read ack gave no data");
  dma_cause_a: assert property (dma_rvalid |-> $past(dma_ack && transfer_request && !setup_r[0]))
    else $error("read data without read ack");
  drop_on_write_a: assert property (wr_cnt || wr_setup |=> !transfer_request)
    else $error("request held across a register write");
  eot_stops_a: assert property (end_of_transfer && transfer_request |=> !transfer_request)
    else $error("request survived end of transfer");
  req_needs_count_a: assert property (transfer_request && !$past(cmd_stb)
      |-> cnt_r != 16'h0000 && setup_r[`SETUP_GATE_BIT])
    else $error("request with zero count or gate off");
endmodule : xfer_link_sva

//--- xfer_pkg.sv
// Types shared by both ends of the transfer setup link.
package xfer_pkg;

  typedef enum logic [1:0] {
    BURST_SINGLE = 2'b00,
    BURST_FOUR   = 2'b01,
    BURST_EIGHT  = 2'b10,
    BURST_RSVD   = 2'b11
  } burst_e;

  typedef enum logic [2:0] {
    SEL_ISO_A    = 3'b000,
    SEL_ISO_B    = 3'b001,
    SEL_PERIODIC = 3'b010,
    SEL_ASYNC    = 3'b011
  } buf_sel_e;

  typedef enum logic [1:0] {
    H_IDLE    = 2'b01,
    H_WAIT_RD = 2'b10
  } host_state_e;

endpackage : xfer_pkg
